// ==== dv/sitp_checker.sv ====
/* assertion checker for the sensor target port, bound to its ports
   assumes one clock domain and the active-low asynchronous reset */
`timescale 1ns/100ps
module sitp_checker (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // watched outputs
    input wire serial_data_pin_oe_ff,
    input wire reg_wr_strobe_ff,
    input wire [7:0] reg_wr_addr_ff,
    input wire [7:0] reg_wr_data_ff,
    input wire [7:0] reg_rd_addr_ff,
    input wire bus_busy_ff,
    input wire wdt_enable_ff,
    input wire wdt_long_ff,
    input wire wdt_reset_ff
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // write port pulses only inside a transfer
    chk_strobe_pulse: assert property (reg_wr_strobe_ff |=> !reg_wr_strobe_ff)
        else $error("write strobe longer than one cycle");
    chk_strobe_busy: assert property (reg_wr_strobe_ff |-> bus_busy_ff)
        else $error("write strobe outside a transfer");
    chk_data_hold: assert property ($changed(reg_wr_data_ff) |-> reg_wr_strobe_ff)
        else $error("write data moved without a strobe");
    // the data line is pulled only while the bus is busy
    chk_oe_in_xfer: assert property (
        serial_data_pin_oe_ff |-> bus_busy_ff || $past(bus_busy_ff))
        else $error("data line pulled while bus idle");
    // read pointer steps by one or restarts at the written register
    chk_rd_step: assert property ($changed(reg_rd_addr_ff) |->
        reg_rd_addr_ff == $past(reg_rd_addr_ff) + 8'h01 || reg_rd_addr_ff == reg_wr_addr_ff)
        else $error("read pointer jumped");
    // watchdog pulse is short, only when enabled, and frees the bus
    chk_wdt_pulse: assert property (wdt_reset_ff |=> !wdt_reset_ff)
        else $error("watchdog pulse longer than one cycle");
    chk_wdt_release: assert property (
        wdt_reset_ff |-> ##[0:2] (!serial_data_pin_oe_ff && !bus_busy_ff))
        else $error("watchdog did not free the bus");
    chk_wdt_enabled: assert property (wdt_reset_ff |-> wdt_enable_ff)
        else $error("watchdog fired while disabled");
    // control bits only follow a write to the control register
    chk_cfg_source: assert property (
        $changed(wdt_enable_ff) || $changed(wdt_long_ff) |-> reg_wr_addr_ff == 8'h34 &&
        wdt_enable_ff == reg_wr_data_ff[2] && wdt_long_ff == reg_wr_data_ff[1])
        else $error("watchdog control changed without its write");
endmodule // sitp_checker

bind sitp_target_port sitp_checker u_chk (.clock(clock), .reset_n(reset_n),
    .serial_data_pin_oe_ff(serial_data_pin_oe_ff), .reg_wr_strobe_ff(reg_wr_strobe_ff),
    .reg_wr_addr_ff(reg_wr_addr_ff), .reg_wr_data_ff(reg_wr_data_ff),
    .reg_rd_addr_ff(reg_rd_addr_ff), .bus_busy_ff(bus_busy_ff),
    .wdt_enable_ff(wdt_enable_ff), .wdt_long_ff(wdt_long_ff), .wdt_reset_ff(wdt_reset_ff));

// ==== dv/sitp_ctrl_model.sv ====
/* behavioural bus controller for the serial clock and data lines
   drives the clock directly; assumes a pull-up on the data line, resolved by the bench */
`timescale 1ns/100ps
module sitp_ctrl_model (
    // pacing clock
    input wire clock,
    // bus lines
    output logic scl,
    output logic sda_low,
    input wire sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // wait falling edges; every line change lands there
    task automatic q(input int n);
        repeat (n) @(negedge clock);
    endtask
    // long low phase leaves room for the port's drive latency
    task automatic bitx(input logic b, output logic r);
        q(5);
        sda_low = !b;
        q(1);
        scl = 1'b1;
        q(2);
        r = sda;
        scl = 1'b0;
    endtask
    // start or repeated start; hold leaves the clock high
    task automatic start(input bit hold);
        q(5);
        sda_low = 1'b0;
        q(1);
        scl = 1'b1;
        q(2);
        sda_low = 1'b1;
        q(2);
        if (!hold) scl = 1'b0;
    endtask
    task automatic stop();
        q(5);
        sda_low = 1'b1;
        q(1);
        scl = 1'b1;
        q(2);
        sda_low = 1'b0;
        q(4);
    endtask
    // byte out msb first; noack stops before the ninth clock
    task automatic wbyte(input logic [7:0] d, input bit noack, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        ack = 1'b0;
        if (!noack) begin
            bitx(1'b1, r);
            ack = (r === 1'b0);
        end
    endtask
    // byte in; last answers with a not-acknowledge
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
        bitx(last, r);
    endtask
endmodule // sitp_ctrl_model

// ==== dv/sitp_target_port_tb.sv ====
/* self-checking bench: controller model on the bus, register file and
   reference memory here; assumes the design files under hw/ */
`timescale 1ns/100ps
module sitp_target_port_tb;
    localparam int WS = 40;
    localparam int WL = 200;
    logic clock, reset_n, addr_sel_pin, ack;
    wire scl, sda_low, sda, oe, sda_out, strobe, busy, wen, wlong, wrst;
    wire [7:0] wa, wd, ra;
    wire [6:0] tgt = addr_sel_pin ? 7'h19 : 7'h18;
    logic [7:0] rf [256];
    logic [7:0] exp_mem [256];
    logic [15:0] wq [$];
    int ptr, fail_count, n_tests, cyc;
    // open drain with pull-up
    assign sda = !((oe === 1'b1 && sda_out === 1'b0) || sda_low === 1'b1);
    sitp_target_port #(.WDT_SHORT_CYC(WS), .WDT_LONG_CYC(WL)) DUT (
        .clock(clock), .reset_n(reset_n), .serial_clock_pin(scl), .serial_data_pin_in(sda),
        .serial_data_pin_out_ff(sda_out), .serial_data_pin_oe_ff(oe),
        .addr_sel_pin(addr_sel_pin), .reg_wr_strobe_ff(strobe), .reg_wr_addr_ff(wa),
        .reg_wr_data_ff(wd), .reg_rd_addr_ff(ra), .reg_rd_data(rf[ra]), .bus_busy_ff(busy),
        .wdt_enable_ff(wen), .wdt_long_ff(wlong), .wdt_reset_ff(wrst));
    sitp_ctrl_model u_ctrl (.clock(clock), .scl(scl), .sda_low(sda_low), .sda(sda));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // register file; strobes logged for the store count
    always @(posedge clock) begin
        if (strobe === 1'b1) begin
            rf[wa] <= wd;
            wq.push_back({wa, wd});
        end
    end
    // hang guard, well above the expected run
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp, input string what);
        cmp8({7'h00, got}, {7'h00, exp}, what);
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one write transfer; extra sends a second data byte
    task automatic do_write(input logic [6:0] a, input logic [7:0] r, input logic [7:0] v,
                            input bit extra);
        logic hit;
        hit = (a == tgt);
        wq.delete();
        u_ctrl.start(0);
        u_ctrl.wbyte({a, 1'b0}, 0, ack);
        cmp1(ack, hit, "address ack");
        if (hit) begin
            u_ctrl.wbyte(r, 0, ack);
            cmp1(ack, 1'b1, "register ack");
            u_ctrl.wbyte(v, 0, ack);
            cmp1(ack, 1'b1, "data ack");
            if (extra) u_ctrl.wbyte(~v, 0, ack);
            if (extra) cmp1(ack, 1'b0, "extra byte ack");
            exp_mem[r] = v;
            ptr = r;
        end
        u_ctrl.stop();
        u_ctrl.q(250);
        cmp1(busy, 1'b0, "busy after stop");
        cmp8(8'(wq.size()), {7'h00, hit}, "stores");
        if (hit) cmp8(wq[0][15:8], r, "stored address");
        if (hit) cmp8(wq[0][7:0], v, "stored data");
    endtask
    // read n bytes; setreg puts a register phase first
    task automatic do_read(input bit setreg, input logic [7:0] r, input int n);
        logic [7:0] got;
        wq.delete();
        if (setreg) u_ctrl.start(0);
        if (setreg) u_ctrl.wbyte({tgt, 1'b0}, 0, ack);
        if (setreg) u_ctrl.wbyte(r, 0, ack);
        if (setreg) ptr = r;
        u_ctrl.start(0);
        u_ctrl.wbyte({tgt, 1'b1}, 0, ack);
        cmp1(ack, 1'b1, "read address ack");
        for (int k = 0; k < n; k++) begin
            u_ctrl.rbyte(k == n - 1, got);
            cmp8(got, exp_mem[8'(ptr + k)], "read data");
        end
        u_ctrl.q(6);
        cmp1(oe, 1'b0, "released after nack");
        u_ctrl.stop();
        cmp1(busy, 1'b0, "busy after read");
        cmp8(8'(wq.size()), 8'h00, "stores during read");
    endtask
    // stall with the ack pending and time the watchdog; 300 means never
    task automatic stall(input logic [7:0] cfg, input int lim);
        int n;
        do_write(tgt, 8'h34, cfg, 0);
        cmp1(wen, cfg[2], "watchdog enable");
        cmp1(wlong, cfg[1], "watchdog period");
        u_ctrl.start(0);
        u_ctrl.wbyte({tgt, 1'b0}, 1, ack);
        n = 0;
        while (oe !== 1'b1 && n < 20) begin
            u_ctrl.q(1);
            n++;
        end
        n = 0;
        while (wrst !== 1'b1 && n < 300) begin
            u_ctrl.q(1);
            n++;
        end
        cmp1(n >= lim - 4 && n <= lim + 4, 1'b1, "watchdog time");
        u_ctrl.q(2);
        if (lim < 300) cmp1(oe | busy, 1'b0, "freed by watchdog");
        u_ctrl.bitx(1'b1, ack);
        u_ctrl.stop();
        u_ctrl.q(250);
    endtask
    initial begin
        reset_n = 1'b0;
        addr_sel_pin = 1'b0;
        void'($urandom(32'hc217c2df));
        for (int i = 0; i < 256; i++) begin
            rf[i] = 8'($urandom);
            exp_mem[i] = rf[i];
        end
        repeat (6) @(negedge clock);
        reset_n = 1'b1;
        u_ctrl.q(4);
        do_read(0, 8'h00, 3);
        $display("test reset pointer done");
        // both strap settings against both bus addresses
        for (int s = 0; s < 2; s++) begin
            addr_sel_pin = s[0];
            u_ctrl.q(4);
            do_write(7'h18, 8'($urandom) & 8'h1F, 8'($urandom), 0);
            do_write(7'h19, 8'($urandom) & 8'h1F, 8'($urandom), 0);
        end
        $display("test address select done");
        do_write(tgt, 8'h7E, 8'($urandom), 1);
        do_read(1, 8'hFE, 4);
        do_read(0, 8'h00, 2);
        $display("test write and read done");
        u_ctrl.start(1);
        u_ctrl.stop();
        cmp1(busy, 1'b1, "ignored stop");
        do_write(tgt, 8'h05, 8'($urandom), 0);
        do_read(0, 8'h00, 1);
        $display("test start stop done");
        stall(8'h04, WS);
        stall(8'h06, WL);
        $display("test watchdog done");
        // reset in mid-run clears the read start and the watchdog bits
        reset_n = 1'b0;
        u_ctrl.q(3);
        reset_n = 1'b1;
        u_ctrl.q(4);
        cmp1(wen | wlong, 1'b0, "watchdog bits after reset");
        ptr = 0;
        do_read(0, 8'h00, 2);
        stall(8'h00, 300);
        $display("test mid-run reset done");
        stop_test();
    end
endmodule // sitp_target_port_tb

// ==== hw/sitp_defs.vh ====
/*
 * Shared constants of the sensor I2C target port: bus addresses,
 * watchdog control byte layout, reset values and watchdog timing.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef SITP_DEFS_VH
`define SITP_DEFS_VH

// target addresses chosen by the address-select pin
`define SITP_TGT_ADDR_LO 7'h18
`define SITP_TGT_ADDR_HI 7'h19

// register byte that holds the watchdog control bits
`define SITP_WDT_CTRL_ADDR 8'h34
`define SITP_WDT_EN_BIT 2
`define SITP_WDT_SEL_BIT 1
`define SITP_WDT_EN_RST 1'b0
`define SITP_WDT_SEL_RST 1'b0

// read start pointer before any register address was written
`define SITP_RD_START_RST 8'h00

// watchdog periods in ms, and the system clock rate in kHz
`define SITP_WDT_SHORT_MS 1
`define SITP_WDT_LONG_MS 50
`define SITP_CLK_KHZ 125000

`endif

// ==== hw/sitp_pin_sync.v ====
/*
 * Two-flop synchronisers for the bus pins and the address-select pin,
 * with one extra stage per bit so the caller can find edges.
 * Assumes asynchronous pin inputs and the system clock domain.
 */
`timescale 1ns/100ps
module sitp_pin_sync #(
    parameter WIDTH = 3,
    parameter [WIDTH-1:0] IDLE_LVL = {WIDTH{1'b1}}
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // raw pins
    input wire [WIDTH-1:0] pin_in,
    // synchronised level and its value one cycle earlier
    output reg [WIDTH-1:0] level_ff,
    output reg [WIDTH-1:0] prev_ff
);

    reg [WIDTH-1:0] meta_ff;

    // first stage feeds only the second; bus lines idle high
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff <= IDLE_LVL;
            level_ff <= IDLE_LVL;
            prev_ff <= IDLE_LVL;
        end else begin
            meta_ff <= pin_in;
            level_ff <= meta_ff;
            prev_ff <= level_ff;
        end
    end

endmodule // sitp_pin_sync

// ==== hw/sitp_target_port.v ====
/*
 * I2C target port of a sensor: address match, register address and
 * single-byte writes, auto-incrementing reads, lock-up watchdog.
 * Assumes open-drain pins resolved outside, a register file on the same
 * clock answering rd_addr combinationally on rd_data, and the bus clock
 * well below a sixth of the system clock.
 */
`timescale 1ns/100ps
`include "sitp_defs.vh"

module sitp_target_port #(
    parameter WDT_SHORT_CYC = `SITP_WDT_SHORT_MS * `SITP_CLK_KHZ,
    parameter WDT_LONG_CYC = `SITP_WDT_LONG_MS * `SITP_CLK_KHZ,
    parameter WDT_CNT_W = 23
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // bus pins, open drain
    input wire serial_clock_pin,
    input wire serial_data_pin_in,
    output reg serial_data_pin_out_ff,
    output reg serial_data_pin_oe_ff,
    // address select strap
    input wire addr_sel_pin,
    // register write request
    output reg reg_wr_strobe_ff,
    output reg [7:0] reg_wr_addr_ff,
    output reg [7:0] reg_wr_data_ff,
    // register read port
    output reg [7:0] reg_rd_addr_ff,
    input wire [7:0] reg_rd_data,
    // status
    output reg bus_busy_ff,
    output reg wdt_enable_ff,
    output reg wdt_long_ff,
    output reg wdt_reset_ff
);

    // engine states; S_WAIT parks the port until the next start or stop
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_ADDR = 4'h1;
    localparam [3:0] S_ACK_ADDR = 4'h2;
    localparam [3:0] S_REG = 4'h3;
    localparam [3:0] S_ACK_REG = 4'h4;
    localparam [3:0] S_DATA = 4'h5;
    localparam [3:0] S_ACK_DATA = 4'h6;
    localparam [3:0] S_TX = 4'h7;
    localparam [3:0] S_TX_ACK = 4'h8;
    localparam [3:0] S_TX_NEXT = 4'h9;
    localparam [3:0] S_WAIT = 4'hA;

    // synchronised pins and the watchdog pulse
    wire [2:0] pin_level;
    wire [2:0] pin_prev;
    wire wdt_fire;

    // engine state, bit count, shift register, remembered read start
    reg [3:0] st_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shreg_ff;
    reg [7:0] rd_start_ff;
    reg scl_low_seen_ff;

    // bit 2 clock, bit 1 data, bit 0 address select
    sitp_pin_sync #(
        .WIDTH(3),
        .IDLE_LVL(3'h6)
    ) u_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin_in({serial_clock_pin, serial_data_pin_in, addr_sel_pin}),
        .level_ff(pin_level),
        .prev_ff(pin_prev)
    );

    // edges and bus conditions seen through the synchronisers
    wire scl = pin_level[2];
    wire sda = pin_level[1];
    wire scl_rise = pin_level[2] & ~pin_prev[2];
    wire scl_fall = ~pin_level[2] & pin_prev[2];
    wire start_det = scl & pin_prev[2] & pin_prev[1] & ~sda;
    wire stop_det = scl & pin_prev[2] & ~pin_prev[1] & sda;
    // stop counts only once the clock went low after the start
    wire stop_ok = stop_det & scl_low_seen_ff;

    // only 7-bit addresses exist; the strap picks one of two
    function [6:0] target_addr;
        input sel;
        begin
            target_addr = sel ? `SITP_TGT_ADDR_HI : `SITP_TGT_ADDR_LO;
        end
    endfunction

    // byte shifted in, msb first; on the eighth bit the direction bit
    function [7:0] shift_in;
        input [7:0] cur;
        input bit_in;
        begin
            shift_in = {cur[6:0], bit_in};
        end
    endfunction

    // the watchdog only ever sees the port pulling the data line
    sitp_watchdog #(
        .CNT_W(WDT_CNT_W),
        .SHORT_CYC(WDT_SHORT_CYC),
        .LONG_CYC(WDT_LONG_CYC)
    ) u_wdt (
        .clock(clock),
        .reset_n(reset_n),
        .enable(wdt_enable_ff),
        .long_sel(wdt_long_ff),
        .holding(serial_data_pin_oe_ff),
        .activity(scl_rise | scl_fall),
        .timeout_ff(wdt_fire)
    );

    // protocol engine: samples on clock rise, changes data on clock fall
    // bus timing leaves several system clocks between a fall and the next rise
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= S_IDLE;
            bit_cnt_ff <= 4'h0;
            shreg_ff <= 8'h00;
            rd_start_ff <= `SITP_RD_START_RST;
            scl_low_seen_ff <= 1'b0;
            serial_data_pin_out_ff <= 1'b0;
            serial_data_pin_oe_ff <= 1'b0;
            reg_wr_strobe_ff <= 1'b0;
            reg_wr_addr_ff <= 8'h00;
            reg_wr_data_ff <= 8'h00;
            reg_rd_addr_ff <= `SITP_RD_START_RST;
            bus_busy_ff <= 1'b0;
            wdt_enable_ff <= `SITP_WDT_EN_RST;
            wdt_long_ff <= `SITP_WDT_SEL_RST;
            wdt_reset_ff <= 1'b0;
        end else begin
            // pulses drop back by themselves after one cycle
            reg_wr_strobe_ff <= 1'b0;
            wdt_reset_ff <= wdt_fire;
            // line only ever pulled low; the pull-up makes the high
            serial_data_pin_out_ff <= 1'b0;
            if (scl_fall) begin
                scl_low_seen_ff <= 1'b1;
            end
            // checked first: a stuck bus is freed even during a start or stop
            if (wdt_fire) begin
                // let go of the bus and forget the transfer
                st_ff <= S_IDLE;
                serial_data_pin_oe_ff <= 1'b0;
                bus_busy_ff <= 1'b0;
                bit_cnt_ff <= 4'h0;
            end else if (start_det) begin
                // plain or repeated start both restart address phase
                st_ff <= S_ADDR;
                bus_busy_ff <= 1'b1;
                serial_data_pin_oe_ff <= 1'b0;
                bit_cnt_ff <= 4'h0;
                scl_low_seen_ff <= 1'b0;
            end else if (stop_ok) begin
                // genuine stop; an early one falls through unnoticed
                st_ff <= S_IDLE;
                bus_busy_ff <= 1'b0;
                serial_data_pin_oe_ff <= 1'b0;
                bit_cnt_ff <= 4'h0;
            end else begin
                // flow: address, then register and one data byte for a write,
                // or sent bytes until the controller stops acknowledging;
                // a foreign address or a surplus byte parks the engine
                case (st_ff)
                    // receive one byte; the fall after the eighth rise ends it
                    S_ADDR, S_REG, S_DATA: begin
                        if (scl_rise) begin
                            shreg_ff <= shift_in(shreg_ff, sda);
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall && bit_cnt_ff == 4'h8) begin
                            bit_cnt_ff <= 4'h0;
                            if (st_ff == S_ADDR) begin
                                // no 10-bit header can ever match these
                                if (shreg_ff[7:1] == target_addr(pin_level[0])) begin
                                    serial_data_pin_oe_ff <= 1'b1;
                                    st_ff <= S_ACK_ADDR;
                                    // direction bit chosen here, read or write
                                    if (shreg_ff[0]) begin
                                        reg_rd_addr_ff <= rd_start_ff;
                                    end
                                end else begin
                                    st_ff <= S_WAIT;
                                end
                            end else if (st_ff == S_REG) begin
                                rd_start_ff <= shreg_ff;
                                reg_wr_addr_ff <= shreg_ff;
                                serial_data_pin_oe_ff <= 1'b1;
                                st_ff <= S_ACK_REG;
                            end else begin
                                // single byte stored at the register just sent
                                reg_wr_data_ff <= shreg_ff;
                                reg_wr_strobe_ff <= 1'b1;
                                if (reg_wr_addr_ff == `SITP_WDT_CTRL_ADDR) begin
                                    wdt_enable_ff <= shreg_ff[`SITP_WDT_EN_BIT];
                                    wdt_long_ff <= shreg_ff[`SITP_WDT_SEL_BIT];
                                end
                                serial_data_pin_oe_ff <= 1'b1;
                                st_ff <= S_ACK_DATA;
                            end
                        end
                    end
                    // ninth clock of the address byte; our acknowledge stands
                    S_ACK_ADDR: begin
                        if (scl_fall) begin
                            if (shreg_ff[0]) begin
                                // first read bit goes out on this same fall
                                shreg_ff <= reg_rd_data;
                                serial_data_pin_oe_ff <= ~reg_rd_data[7];
                                st_ff <= S_TX;
                            end else begin
                                serial_data_pin_oe_ff <= 1'b0;
                                st_ff <= S_REG;
                            end
                        end
                    end
                    // register byte acknowledged; release and wait for data
                    S_ACK_REG: begin
                        if (scl_fall) begin
                            serial_data_pin_oe_ff <= 1'b0;
                            st_ff <= S_DATA;
                        end
                    end
                    S_ACK_DATA: begin
                        // later bytes are left unacknowledged, never stored
                        if (scl_fall) begin
                            serial_data_pin_oe_ff <= 1'b0;
                            st_ff <= S_WAIT;
                        end
                    end
                    // count rises; every fall but the last puts out the next bit
                    S_TX: begin
                        if (scl_rise) begin
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_ff == 4'h8) begin
                                // hand the ninth clock to the controller
                                serial_data_pin_oe_ff <= 1'b0;
                                bit_cnt_ff <= 4'h0;
                                st_ff <= S_TX_ACK;
                            end else begin
                                shreg_ff <= {shreg_ff[6:0], 1'b0};
                                serial_data_pin_oe_ff <= ~shreg_ff[6];
                            end
                        end
                    end
                    // the controller owns the ninth clock of every sent byte
                    S_TX_ACK: begin
                        if (scl_rise) begin
                            reg_rd_addr_ff <= reg_rd_addr_ff + 8'h01;
                            // high during the ninth clock means no more bytes
                            st_ff <= sda ? S_WAIT : S_TX_NEXT;
                        end
                    end
                    S_TX_NEXT: begin
                        // read data has had many cycles to follow the address
                        if (scl_fall) begin
                            shreg_ff <= reg_rd_data;
                            serial_data_pin_oe_ff <= ~reg_rd_data[7];
                            st_ff <= S_TX;
                        end
                    end
                    S_WAIT: begin
                        // passive until the next start or stop
                        serial_data_pin_oe_ff <= 1'b0;
                    end
                    // unused codes drop back to idle rather than hang
                    default: begin
                        serial_data_pin_oe_ff <= 1'b0;
                        st_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // sitp_target_port

// ==== hw/sitp_watchdog.v ====
/*
 * Lock-up watchdog: counts while the port pulls the data line low with
 * no clock activity, and pulses once when the chosen period runs out.
 * Assumes inputs from logic on the same clock.
 */
`timescale 1ns/100ps
module sitp_watchdog #(
    parameter CNT_W = 23,
    parameter SHORT_CYC = 125000,
    parameter LONG_CYC = 6250000
) (
    // clock and reset
    input wire clock,
    input wire reset_n,
    // control
    input wire enable,
    input wire long_sel,
    // observed activity
    input wire holding,
    input wire activity,
    // one-cycle timeout
    output reg timeout_ff
);

    // limits worked out at full width, then cut to the counter on purpose
    localparam [31:0] SHORT_FULL = SHORT_CYC - 1;
    localparam [31:0] LONG_FULL = LONG_CYC - 1;
    localparam [CNT_W-1:0] SHORT_LIM = SHORT_FULL[CNT_W-1:0];
    localparam [CNT_W-1:0] LONG_LIM = LONG_FULL[CNT_W-1:0];

    reg [CNT_W-1:0] cnt_ff;
    wire [CNT_W-1:0] limit = long_sel ? LONG_LIM : SHORT_LIM;

    // any clock edge or release proves the bus is not stuck on us
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= {CNT_W{1'b0}};
            timeout_ff <= 1'b0;
        end else begin
            timeout_ff <= 1'b0;
            if (!enable || !holding || activity) begin
                cnt_ff <= {CNT_W{1'b0}};
            end else if (cnt_ff >= limit) begin
                cnt_ff <= {CNT_W{1'b0}};
                timeout_ff <= 1'b1;
            end else begin
                cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // sitp_watchdog
